// File: rtl/plr_pkg.sv
// package for the power loss ride-through sequencer
// assumes a 40 MHz system clock and a classic wishbone register bus
package plr_pkg;
  // clock and tick
  localparam int unsigned CLK_HZ          = 40000000;
  localparam int unsigned TICK_MS         = 100;
  localparam int unsigned TICK_CYCLES     = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned DROP_FAULT_US   = 15000;
  localparam int unsigned DROP_CYCLES     = CLK_HZ / 1000000 * DROP_FAULT_US;

  // restart modes
  localparam logic [1:0] MODE_DISABLED    = 2'h0;
  localparam logic [1:0] MODE_RIDE_TIME   = 2'h1;
  localparam logic [1:0] MODE_CTRL_BACKED = 2'h2;

  // register offsets (byte addresses)
  localparam logic [7:0] REG_MODE    = 8'h00;
  localparam logic [7:0] REG_RIDE    = 8'h04;
  localparam logic [7:0] REG_BLOCK   = 8'h08;
  localparam logic [7:0] REG_RAMP    = 8'h0C;
  localparam logic [7:0] REG_UVLVL   = 8'h10;
  localparam logic [7:0] REG_STATUS  = 8'h14;
  localparam logic [7:0] REG_IRQ_ST  = 8'h18;
  localparam logic [7:0] REG_IRQ_EN  = 8'h1C;
  localparam logic [7:0] REG_IRQ_CLR = 8'h20;

  // reset values, times in 0.1 s ticks, level in volts
  localparam logic [1:0]  RST_MODE   = 2'h0;
  localparam logic [7:0]  RST_RIDE   = 8'h01;
  localparam logic [7:0]  RST_BLOCK  = 8'h02;
  localparam logic [7:0]  RST_RAMP   = 8'h03;
  localparam logic [9:0]  RST_UVLVL  = 10'h0BE;
  localparam logic [9:0]  MIN_UVLVL  = 10'h096;
  localparam logic [7:0]  MIN_BLOCK  = 8'h01;
  localparam logic [7:0]  MAX_BLOCK  = 8'h32;
  localparam logic [7:0]  MAX_RAMP   = 8'h32;

  // interrupt bits
  localparam int unsigned IRQ_LOSS   = 0;
  localparam int unsigned IRQ_FAULT  = 1;
  localparam int unsigned IRQ_RUN    = 2;
  localparam int unsigned IRQ_W      = 3;

  typedef enum logic [2:0] {
    ST_IDLE, ST_RUN, ST_LOSS, ST_BLOCK, ST_SEARCH, ST_RAMP, ST_TRIP
  } plr_state_type;
endpackage

// File: rtl/plr_tick.sv
// 0.1 s tick divider
// assumes one system clock with synchronous active-high reset
`timescale 1ns/100ps
module plr_tick
  import plr_pkg::*;
#(
  parameter int unsigned CYCLES = TICK_CYCLES
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic restart,
  output logic      tick
);
  logic [31:0] cnt_reg;

  // restart aligns the first tick to the start of a timed phase
  always_ff @(posedge clk) begin
    if (rst || restart) begin
      cnt_reg <= 32'h0;
      tick    <= 1'b0;
    end else if (cnt_reg == 32'(CYCLES - 1)) begin
      cnt_reg <= 32'h0;
      tick    <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 32'h1;
      tick    <= 1'b0;
    end
  end
endmodule // plr_tick

// File: rtl/plr_irq.sv
// sticky interrupt status with enable and write-one-to-clear
// assumes event pulses are one cycle wide
`timescale 1ns/100ps
module plr_irq
  import plr_pkg::*;
#(
  parameter int unsigned W = IRQ_W
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] evt,
  input  wire logic [W-1:0] clr,
  input  wire logic [W-1:0] en,
  output logic      [W-1:0] status,
  output logic              irq
);
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      // set wins over a clear in the same cycle
      always_ff @(posedge clk) begin
        if (rst)
          status[i] <= 1'b0;
        else if (evt[i])
          status[i] <= 1'b1;
        else if (clr[i])
          status[i] <= 1'b0;
      end
    end
  endgenerate

  assign irq = |(status & en);
endmodule // plr_irq

// File: rtl/plr_seq.sv
// power loss ride-through sequencer, top level with wishbone registers
// assumes synchronous inputs, 40 MHz CLK, synchronous SYS_RST
//
// Notes on behaviour
// - mode disabled: a power loss longer than 15 ms trips with the main undervoltage fault; a shorter one restarts.
// - ride-time mode: restart if power returns within the ride-through time.
// - ride-time mode: fault once the outage outlasts the ride-through time.
// - control-backed mode: restart on return if control power held; never fault.
// - ride-through time 0 to 25.5 s, default 0.1 s, used only in ride-time mode.
// - output stays blocked at least the block time, 0.1 to 5.0 s, default 0.2 s.
// - if block time exceeds ride time, resume only after the block time.
// - after speed search, ramp voltage back over the ramp time, default 0.3 s.
// - undervoltage trip level programmable from 150, default 190 V low class.
// - high voltage class doubles the trip level range and default.
// - error outputs suppressed while recovering from a power loss.
// - mode disabled: fault when a loss during operation exceeds 15 ms.
`timescale 1ns/100ps
module plr_seq
  import plr_pkg::*;
#(
  parameter int unsigned TICK_CYC = TICK_CYCLES,
  parameter int unsigned DROP_CYC = DROP_CYCLES
) (
  input  wire logic        CLK,
  input  wire logic        SYS_RST,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  input  wire logic [9:0]  DC_BUS_VOLTS,
  input  wire logic        HIGH_CLASS,
  input  wire logic        CTRL_POWER_OK,
  input  wire logic        RUN_CMD,
  input  wire logic        SEARCH_DONE,
  input  wire logic        ERR_IN,
  output logic             OUTPUT_ENABLE,
  output logic             SEARCH_START,
  output logic      [7:0]  RAMP_LEVEL,
  output logic             MAIN_UNDERVOLTAGE_FAULT,
  output logic             ERR_OUT,
  output logic             IRQ
);
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [1:0]        restart_mode_select_reg;
  logic [7:0]        ride_thru_time_reg;
  logic [7:0]        min_output_block_time_reg;
  logic [7:0]        voltage_recovery_ramp_time_reg;
  logic [9:0]        undervoltage_trip_level_reg;
  logic [IRQ_W-1:0]  irq_en_reg;
  logic [IRQ_W-1:0]  irq_clr;
  logic [IRQ_W-1:0]  irq_evt;
  logic [IRQ_W-1:0]  irq_status;
  plr_state_type     state_reg;
  logic [7:0]        ticks_reg;
  logic [31:0]       drop_cnt_reg;
  logic              tick;
  logic              phase_start;
  logic              wr;
  logic              wr_lane0;
  logic              wr_lanes01;
  logic              main_lost;
  logic [10:0]       trip_level;
  logic [9:0]        wr_level;
  logic [7:0]        wr_block;
  logic [7:0]        wr_ramp;

  // writes land on the edge at which the master samples ack high, not earlier
  assign wr         = WB_CYC_I && WB_STB_I && WB_WE_I && WB_ACK_O;
  assign wr_lane0   = wr && WB_SEL_I[0];
  assign wr_lanes01 = wr && (WB_SEL_I[1:0] == 2'h3);
  assign wr_level   = (WB_DAT_I[9:0] < MIN_UVLVL) ? MIN_UVLVL : WB_DAT_I[9:0];
  assign wr_block   = (WB_DAT_I[7:0] < MIN_BLOCK) ? MIN_BLOCK :
                      (WB_DAT_I[7:0] > MAX_BLOCK) ? MAX_BLOCK : WB_DAT_I[7:0];
  assign wr_ramp    = (WB_DAT_I[7:0] > MAX_RAMP) ? MAX_RAMP : WB_DAT_I[7:0];

  // mode 3 is not a valid setting, kept at the old value
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      restart_mode_select_reg        <= RST_MODE;
      ride_thru_time_reg             <= RST_RIDE;
      min_output_block_time_reg      <= RST_BLOCK;
      voltage_recovery_ramp_time_reg <= RST_RAMP;
      undervoltage_trip_level_reg    <= RST_UVLVL;
      irq_en_reg                     <= '0;
    end else begin
      if (wr_lane0 && WB_ADR_I == REG_MODE && WB_DAT_I[1:0] != 2'h3)
        restart_mode_select_reg <= WB_DAT_I[1:0];
      if (wr_lane0 && WB_ADR_I == REG_RIDE)
        ride_thru_time_reg <= WB_DAT_I[7:0];
      if (wr_lane0 && WB_ADR_I == REG_BLOCK)
        min_output_block_time_reg <= wr_block;
      if (wr_lane0 && WB_ADR_I == REG_RAMP)
        voltage_recovery_ramp_time_reg <= wr_ramp;
      if (wr_lanes01 && WB_ADR_I == REG_UVLVL)
        undervoltage_trip_level_reg <= wr_level;
      if (wr_lane0 && WB_ADR_I == REG_IRQ_EN)
        irq_en_reg <= WB_DAT_I[IRQ_W-1:0];
    end
  end

  assign irq_clr = (wr_lane0 && WB_ADR_I == REG_IRQ_CLR) ? WB_DAT_I[IRQ_W-1:0] : '0;

  // one wait state free: ack the cycle after the request, then drop
  always_ff @(posedge CLK) begin
    if (SYS_RST)
      WB_ACK_O <= 1'b0;
    else
      WB_ACK_O <= WB_CYC_I && WB_STB_I && !WB_ACK_O;
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      WB_DAT_O <= 32'h0;
    end else begin
      case (WB_ADR_I)
        REG_MODE:   WB_DAT_O <= {30'h0, restart_mode_select_reg};
        REG_RIDE:   WB_DAT_O <= {24'h0, ride_thru_time_reg};
        REG_BLOCK:  WB_DAT_O <= {24'h0, min_output_block_time_reg};
        REG_RAMP:   WB_DAT_O <= {24'h0, voltage_recovery_ramp_time_reg};
        REG_UVLVL:  WB_DAT_O <= {22'h0, undervoltage_trip_level_reg};
        REG_STATUS: WB_DAT_O <= {24'h0, 1'b0, state_reg, MAIN_UNDERVOLTAGE_FAULT, main_lost, CTRL_POWER_OK, RUN_CMD};
        REG_IRQ_ST: WB_DAT_O <= {29'h0, irq_status};
        REG_IRQ_EN: WB_DAT_O <= {29'h0, irq_en_reg};
        default:    WB_DAT_O <= 32'h0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // supply detection
  // ----------------------------------------------------------------
  // the higher class compares against twice the programmed level
  assign trip_level = HIGH_CLASS ? {undervoltage_trip_level_reg, 1'b0}
                                 : {1'b0, undervoltage_trip_level_reg};
  assign main_lost  = {1'b0, DC_BUS_VOLTS} < trip_level;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  plr_tick #(.CYCLES(TICK_CYC)) u_tick (
    .clk     (CLK),
    .rst     (SYS_RST),
    .restart (phase_start),
    .tick    (tick)
  );

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  logic ride_expired;
  logic block_done;
  logic drop_long;

  assign ride_expired = ticks_reg >= ride_thru_time_reg;
  assign block_done   = ticks_reg >= min_output_block_time_reg;
  assign drop_long    = drop_cnt_reg >= DROP_CYC;
  assign phase_start  = (state_reg == ST_RUN && main_lost) ||
                        (state_reg == ST_SEARCH && SEARCH_DONE);

  // ticks count from the loss across loss and block phases, so block time
  // is measured from the loss itself and without a second counter
  always_ff @(posedge CLK) begin
    if (SYS_RST || phase_start)
      ticks_reg <= 8'h0;
    else if (tick && ticks_reg != 8'hFF)
      ticks_reg <= ticks_reg + 8'h1;
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST || !main_lost || state_reg != ST_RUN && state_reg != ST_LOSS)
      drop_cnt_reg <= 32'h0;
    else if (!drop_long)
      drop_cnt_reg <= drop_cnt_reg + 32'h1;
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      state_reg <= ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE:
          if (RUN_CMD && !main_lost)
            state_reg <= ST_RUN;
        ST_RUN:
          if (main_lost)
            state_reg <= ST_LOSS;
          else if (!RUN_CMD)
            state_reg <= ST_IDLE;
        ST_LOSS: begin
          if (!RUN_CMD)
            state_reg <= ST_IDLE;
          else if (restart_mode_select_reg == MODE_DISABLED) begin
            if (drop_long)
              state_reg <= ST_TRIP;
            else if (!main_lost)
              state_reg <= ST_BLOCK;
          end else if (restart_mode_select_reg == MODE_RIDE_TIME) begin
            if (main_lost && ride_expired)
              state_reg <= ST_TRIP;
            else if (!main_lost)
              state_reg <= ST_BLOCK;
          end else begin
            if (!CTRL_POWER_OK)
              state_reg <= ST_IDLE;
            else if (!main_lost)
              state_reg <= ST_BLOCK;
          end
        end
        ST_BLOCK:
          if (!RUN_CMD)
            state_reg <= ST_IDLE;
          else if (main_lost)
            state_reg <= ST_LOSS;
          else if (block_done)
            state_reg <= ST_SEARCH;
        ST_SEARCH:
          if (SEARCH_DONE)
            state_reg <= ST_RAMP;
        ST_RAMP:
          if (ticks_reg >= voltage_recovery_ramp_time_reg)
            state_reg <= ST_RUN;
        ST_TRIP:
          state_reg <= ST_TRIP; // cleared only by reset
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  logic recovering;
  assign recovering = state_reg == ST_LOSS || state_reg == ST_BLOCK ||
                      state_reg == ST_SEARCH || state_reg == ST_RAMP;

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      OUTPUT_ENABLE           <= 1'b0;
      SEARCH_START            <= 1'b0;
      RAMP_LEVEL              <= 8'h0;
      MAIN_UNDERVOLTAGE_FAULT <= 1'b0;
      ERR_OUT                 <= 1'b0;
    end else begin
      OUTPUT_ENABLE           <= state_reg == ST_RUN || state_reg == ST_SEARCH || state_reg == ST_RAMP;
      SEARCH_START            <= state_reg == ST_BLOCK && block_done && RUN_CMD && !main_lost;
      RAMP_LEVEL              <= (state_reg == ST_RUN) ? 8'hFF :
                                 (state_reg != ST_RAMP) ? 8'h0 :
                                 (voltage_recovery_ramp_time_reg == 8'h0) ? 8'hFF :
                                 8'((16'(ticks_reg) * 16'hFF) / 16'(voltage_recovery_ramp_time_reg));
      MAIN_UNDERVOLTAGE_FAULT <= state_reg == ST_TRIP;
      ERR_OUT                 <= ERR_IN && !recovering;
    end
  end

  assign irq_evt[IRQ_LOSS]  = state_reg == ST_RUN && main_lost;
  assign irq_evt[IRQ_FAULT] = state_reg == ST_TRIP && !MAIN_UNDERVOLTAGE_FAULT;
  assign irq_evt[IRQ_RUN]   = state_reg == ST_RAMP && ticks_reg >= voltage_recovery_ramp_time_reg;

  plr_irq #(.W(IRQ_W)) u_irq (
    .clk    (CLK),
    .rst    (SYS_RST),
    .evt    (irq_evt),
    .clr    (irq_clr),
    .en     (irq_en_reg),
    .status (irq_status),
    .irq    (IRQ)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_fault_mode;
    @(posedge CLK) disable iff (SYS_RST)
    state_reg == ST_LOSS && restart_mode_select_reg == MODE_CTRL_BACKED |=> state_reg != ST_TRIP;
  endproperty
  a_fault_mode: assert property (p_fault_mode) else $error("fault raised in control-backed mode");

  property p_trip_fault;
    @(posedge CLK) disable iff (SYS_RST)
    state_reg == ST_TRIP |=> MAIN_UNDERVOLTAGE_FAULT;
  endproperty
  a_trip_fault: assert property (p_trip_fault) else $error("trip without fault output");

  property p_block_min;
    @(posedge CLK) disable iff (SYS_RST)
    state_reg == ST_BLOCK && $past(state_reg) == ST_BLOCK |-> !OUTPUT_ENABLE;
  endproperty
  a_block_min: assert property (p_block_min) else $error("output enabled during block");

  property p_err_quiet;
    @(posedge CLK) disable iff (SYS_RST)
    recovering |=> !ERR_OUT;
  endproperty
  a_err_quiet: assert property (p_err_quiet) else $error("error output during recovery");

  sequence s_loss_entry;
    state_reg == ST_RUN && main_lost;
  endsequence
  property p_loss_seq;
    @(posedge CLK) disable iff (SYS_RST)
    s_loss_entry |=> state_reg == ST_LOSS ##1 !OUTPUT_ENABLE;
  endproperty
  a_loss_seq: assert property (p_loss_seq) else $error("loss not followed by blocked output");

  property p_ride_trip;
    @(posedge CLK) disable iff (SYS_RST)
    state_reg == ST_LOSS && RUN_CMD && restart_mode_select_reg == MODE_RIDE_TIME && main_lost && ride_expired
      |=> state_reg == ST_TRIP ##1 MAIN_UNDERVOLTAGE_FAULT;
  endproperty
  a_ride_trip: assert property (p_ride_trip) else $error("ride-through expiry did not trip");

  property p_resume_after_block;
    @(posedge CLK) disable iff (SYS_RST)
    $rose(state_reg == ST_SEARCH) |-> ticks_reg >= min_output_block_time_reg;
  endproperty
  a_resume_after_block: assert property (p_resume_after_block) else $error("resumed before block time");

  property p_no_run_no_restart;
    @(posedge CLK) disable iff (SYS_RST)
    state_reg == ST_BLOCK && !RUN_CMD |=> state_reg == ST_IDLE;
  endproperty
  a_no_run_no_restart: assert property (p_no_run_no_restart) else $error("restart without run command");
endmodule // plr_seq

// File: dv/plr_supply_model.sv
// model of the main supply monitor, the run command source and the speed search
// assumes the sequencer clock; the bench commands every change
`timescale 1ns/100ps
module plr_supply_model (
  input  wire logic       clk,
  input  wire logic       main_on,
  input  wire logic       ctrl_on,
  input  wire logic       run_on,
  input  wire logic [9:0] on_volts,
  input  wire logic [3:0] search_lat,
  input  wire logic       search_start,
  output logic      [9:0] dc_bus_volts,
  output logic            ctrl_power_ok,
  output logic            run_cmd,
  output logic            search_done
);
  int cnt = 0;
  // a collapsed bus reads zero, never a stale level
  assign dc_bus_volts  = main_on ? on_volts : 10'h000;
  assign ctrl_power_ok = ctrl_on;
  // run command held across the outage; only the bench ever drops it
  assign run_cmd       = run_on;
  // search answers after search_lat cycles; the bench ties search_lat to 4, so only one latency is tried
  always_ff @(posedge clk) begin
    if (search_start === 1'b1) begin
      cnt <= int'(search_lat);
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
    search_done <= (cnt == 1);
  end
endmodule // plr_supply_model

// File: dv/test_power_loss_ride_through.sv
// self-checking bench for the power loss ride-through sequencer
// assumes plr_pkg and the supply model; short tick and drop counts
`timescale 1ns/100ps
module test_power_loss_ride_through;
  import plr_pkg::*;
  localparam int TC = 10;
  typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e;} plr_row_type;
  plr_row_type rows [0:14] = '{
    '{1'b0, REG_MODE, 32'h0, 32'h0}, '{1'b0, REG_RIDE, 32'h0, 32'h1},
    '{1'b0, REG_BLOCK, 32'h0, 32'h2}, '{1'b0, REG_RAMP, 32'h0, 32'h3},
    '{1'b0, REG_UVLVL, 32'h0, 32'hBE}, '{1'b0, REG_IRQ_EN, 32'h0, 32'h0},
    '{1'b1, REG_MODE, 32'h3, 32'h0}, '{1'b1, REG_MODE, 32'h2, 32'h2},
    '{1'b1, REG_RIDE, 32'hFF, 32'hFF}, '{1'b1, REG_BLOCK, 32'h0, 32'h1},
    '{1'b1, REG_BLOCK, 32'h40, 32'h32}, '{1'b1, REG_RAMP, 32'h40, 32'h32},
    '{1'b1, REG_UVLVL, 32'h50, 32'h96}, '{1'b1, REG_IRQ_ST, 32'h7, 32'h0},
    '{1'b1, 8'h40, 32'hFF, 32'h0}};
  logic [31:0] lv [0:5] = '{32'h0BE_0BD_1_1, 32'h0BE_0BE_0_0, 32'h0BE_17B_1_1,
                            32'h0BE_17C_1_0, 32'h096_095_0_1, 32'h096_096_0_0};
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat, q;
  logic        ack, ctrl_ok, run, sdone, oe, sstart, fault, err_out, irq, mid;
  logic [9:0]  volts;
  logic [7:0]  ramp;
  logic        hc = 1'b0;
  logic        err_in = 1'b0;
  logic        main_on = 1'b1;
  logic        ctrl_on = 1'b1;
  logic        run_on = 1'b1;
  logic [9:0]  on_volts = 10'h136;
  int          fail_count = 0;
  int          n_checks = 0;
  int          cycles = 0;
  int          n;
  always #12.5 clk = ~clk;
  plr_seq #(.TICK_CYC(TC), .DROP_CYC(6)) plr_seq_inst (.CLK(clk), .SYS_RST(sys_rst), .WB_CYC_I(cyc),
    .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
    .WB_ACK_O(ack), .DC_BUS_VOLTS(volts), .HIGH_CLASS(hc), .CTRL_POWER_OK(ctrl_ok), .RUN_CMD(run),
    .SEARCH_DONE(sdone), .ERR_IN(err_in), .OUTPUT_ENABLE(oe), .SEARCH_START(sstart), .RAMP_LEVEL(ramp),
    .MAIN_UNDERVOLTAGE_FAULT(fault), .ERR_OUT(err_out), .IRQ(irq));
  plr_supply_model plr_supply_model_inst (.clk(clk), .main_on(main_on), .ctrl_on(ctrl_on),
    .run_on(run_on), .on_volts(on_volts), .search_lat(4'h4), .search_start(sstart),
    .dc_bus_volts(volts), .ctrl_power_ok(ctrl_ok), .run_cmd(run), .search_done(sdone));
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task tally_and_finish;
    if (fail_count == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  // request held until ack is sampled high, then released for one cycle at least
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    // one idle edge so a write has landed before the caller looks at outputs
    @(posedge clk);
  endtask
  function automatic logic sig(input int i);
    return (i == 0) ? oe : ((i == 1) ? irq : sstart);
  endfunction
  task wait_hi(input int i, input int lim);
    n = 0;
    while (sig(i) !== 1'b1 && n < lim) begin
      @(posedge clk);
      n++;
    end
  endtask
  task do_reset(input int len);
    main_on <= 1'b1;
    ctrl_on <= 1'b1;
    run_on <= 1'b1;
    err_in <= 1'b0;
    sys_rst <= 1'b1;
    repeat (len) @(posedge clk);
    sys_rst <= 1'b0;
  endtask
  task start_run(input logic [31:0] m, input logic [31:0] r, input logic [31:0] b);
    do_reset(4);
    wb(1'b1, REG_MODE, m);
    wb(1'b1, REG_RIDE, r);
    wb(1'b1, REG_BLOCK, b);
    wb(1'b1, REG_IRQ_EN, 32'h4);
    wait_hi(0, 100);
  endtask
  task outage(input int len);
    main_on <= 1'b0;
    repeat (len) @(posedge clk);
    main_on <= 1'b1;
  endtask
  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      tally_and_finish;
    end
  end
  initial begin
    do_reset(16);
    foreach (rows[i]) begin
      if (rows[i].w) wb(1'b1, rows[i].a, rows[i].d);
      wb(1'b0, rows[i].a, 32'h0);
      chk("register", rows[i].e, q);
    end
    foreach (lv[i]) begin
      wb(1'b1, REG_UVLVL, {22'h0, lv[i][29:20]});
      on_volts <= lv[i][17:8];
      hc <= lv[i][4];
      wb(1'b0, REG_STATUS, 32'h0);
      chk("main lost", {31'h0, lv[i][0]}, {31'h0, q[2]});
    end
    hc <= 1'b0;
    on_volts <= 10'h136;
    // mode disabled: a dip under the drop time rides through, a long one trips
    start_run(32'h0, 32'h1, 32'h2);
    outage(3);
    wait_hi(1, 200);
    chk("fault short dip", 32'h0, fault);
    wb(1'b0, REG_IRQ_ST, 32'h0);
    chk("irq status", 32'h5, q);
    wb(1'b1, REG_IRQ_EN, 32'h0);
    chk("irq masked", 32'h0, irq);
    wb(1'b1, REG_IRQ_EN, 32'h4);
    chk("irq unmasked", 32'h1, irq);
    wb(1'b1, REG_IRQ_CLR, 32'h5);
    chk("irq cleared", 32'h0, irq);
    main_on <= 1'b0;
    repeat (4) @(posedge clk);
    chk("fault early", 32'h0, fault);
    repeat (10) @(posedge clk);
    chk("fault mode off", 32'h1, fault);
    chk("output tripped", 32'h0, oe);
    // ride-time mode: restart inside the window, fault beyond it
    start_run(32'h1, 32'h3, 32'h1);
    outage(15);
    wait_hi(1, 300);
    chk("ride restart", 32'h1, irq);
    chk("ride no fault", 32'h0, fault);
    wb(1'b1, REG_IRQ_CLR, 32'h7);
    main_on <= 1'b0;
    repeat (25) @(posedge clk);
    chk("fault in window", 32'h0, fault);
    repeat (15) @(posedge clk);
    chk("fault past window", 32'h1, fault);
    start_run(32'h1, 32'h0, 32'h2);
    main_on <= 1'b0;
    repeat (4) @(posedge clk);
    chk("zero ride trips", 32'h1, fault);
    // block time longer than ride time, then the recovery ramp
    start_run(32'h1, 32'h1, 32'h5);
    outage(3);
    chk("output blocked", 32'h0, oe);
    wait_hi(2, 100);
    chk("block span", 32'h1, (n + 3 >= 5 * TC) && (n + 3 <= 7 * TC));
    n = 0;
    mid = 1'b0;
    while (irq !== 1'b1 && n < 200) begin
      @(posedge clk);
      n++;
      if (ramp !== 8'h00 && ramp !== 8'hFF) mid = 1'b1;
    end
    chk("ramp span", 32'h1, (n >= 2 * TC + 4) && (n <= 4 * TC + 8));
    chk("ramp climbs", 32'h1, mid);
    // control-power-backed mode: no fault however long the loss
    start_run(32'h2, 32'h1, 32'h2);
    main_on <= 1'b0;
    repeat (100) @(posedge clk);
    chk("backed no fault", 32'h0, fault);
    main_on <= 1'b1;
    wait_hi(1, 300);
    chk("backed restart", 32'h1, irq);
    main_on <= 1'b0;
    ctrl_on <= 1'b0;
    repeat (50) @(posedge clk);
    chk("ctrl lost no fault", 32'h0, fault);
    chk("ctrl lost idle", 32'h0, oe);
    // run command dropped mid-outage: no restart
    start_run(32'h1, 32'h8, 32'h2);
    main_on <= 1'b0;
    repeat (5) @(posedge clk);
    run_on <= 1'b0;
    repeat (5) @(posedge clk);
    main_on <= 1'b1;
    repeat (100) @(posedge clk);
    chk("no restart oe", 32'h0, oe);
    chk("no restart irq", 32'h0, irq);
    // errors pass while running, masked while recovering
    start_run(32'h1, 32'h3, 32'h2);
    err_in <= 1'b1;
    repeat (3) @(posedge clk);
    chk("err running", 32'h1, err_out);
    outage(5);
    repeat (5) @(posedge clk);
    chk("err recovering", 32'h0, err_out);
    wait_hi(1, 300);
    repeat (3) @(posedge clk);
    chk("err after", 32'h1, err_out);
    tally_and_finish;
  end
endmodule // test_power_loss_ride_through
